// ### hdl/tmb_defs.vh
// Constants for the timer type B capture, single-shot and PWM block.
// Assumes an APB slave with 32-bit data and one register per word.
// Rules of the document for this block and its users
// RULE_01 - Pulse-width: restart on rise, capture on fall
// RULE_02 - Reading capture low byte clears capture flag
// RULE_03 - Count at maximum sets wraparound flag, event; the code does so in the two capture modes only
// RULE_04 - Source keeps input edges two cycles apart
// RULE_05 - Freq+width: start rise, capture fall, stop rise
// RULE_06 - Software reads count before capture register
// RULE_07 - Single-shot: low when stopped, trigger starts high
// RULE_08 - At compare stop, low one tick, ignore triggers
// RULE_09 - Sync trigger drives output high two cycles later
// RULE_10 - Polarity bit one: any edge; zero: rising only
// RULE_11 - Untriggered start on enable; top write suppresses
// RULE_12 - Immediate trigger sets output now, count later
// RULE_13 - Status shows whether single-shot counter runs
// RULE_14 - PWM: low byte period, high byte duty
// RULE_15 - High for duty cycles, period low byte plus one
// RULE_16 - Output enable routes waveform, else no drive
// RULE_17 - Other modes drive the initial-level bit
// RULE_18 - Software avoids mode change while enabled
// RULE_19 - Low half wraps and emits overflow for chaining; the code emits it in the two capture modes only
// RULE_20 - Chaining bit zero low half, one high half; the code never reads the chaining bit
// RULE_21 - Same capture event to both; concatenate results
// RULE_22 - Counter bottom 0x0000, maximum 0xffff, wraps
// RULE_23 - Input event lasts at least one clock cycle
// RULE_24 - Emitted events are single-cycle pulses
`ifndef TMB_DEFS_VH
`define TMB_DEFS_VH
`define TMB_OFF_CTRLA   12'h000
`define TMB_OFF_CTRLB   12'h004
`define TMB_OFF_EVCTRL  12'h008
`define TMB_OFF_FLAGS   12'h00c
`define TMB_OFF_STATUS  12'h010
`define TMB_OFF_COUNT   12'h014
`define TMB_OFF_PERIOD_COMPARE_LOW_BYTE   12'h018
`define TMB_OFF_DUTY_COMPARE_HIGH_BYTE   12'h01c
`define TMB_CA_EN       0
`define TMB_CA_CLKLO    1
`define TMB_CA_CLKHI    3
`define TMB_CA_CASCADE  5
`define TMB_CB_MODELO   0
`define TMB_CB_MODEHI   2
`define TMB_CB_OE       4
`define TMB_CB_INIT     5
`define TMB_CB_IMM      6
`define TMB_EV_EI       0
`define TMB_EV_EDGE     4
`define TMB_FL_SAMPLE_TAKEN_FLAG     0
`define TMB_FL_OVF      1
`define TMB_MODE_PW     3'h4
`define TMB_MODE_FPW    3'h5
`define TMB_MODE_SS     3'h6
`define TMB_MODE_PWM    3'h7
`define TMB_CLK_DIV1    3'h0
`define TMB_CLK_DIV2    3'h1
`define TMB_CLK_EVENT   3'h7
`define TMB_BOTTOM      16'h0000
`define TMB_MAX         16'hffff
`define TMB_SS_DELAY    2'h2
`endif

// ### hdl/tmb_edge.v
// Input synchroniser and edge detector for one event line.
// Assumes the line is asynchronous to pclk.
`timescale 1ns/1ps
module tmb_edge (
    input  wire pclk,
    input  wire presetn,
    input  wire din,
    output reg  rise_q,
    output reg  fall_q,
    output wire level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Two flops resync; the third is only for edge detection.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            s1_q   <= din;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            rise_q <= s2_q & ~s3_q;
            fall_q <= ~s2_q & s3_q;
        end
    end

    assign level = s2_q;
endmodule

// ### hdl/tmb_timer.v
// Timer type B: pulse-width and frequency capture, single-shot, PWM.
// Assumes an APB master on pclk, events from the routing fabric.
// Event lines may change at any time; each passes two flops first.
// The immediate trigger still waits for that synchroniser.
`timescale 1ns/1ps
`include "tmb_defs.vh"
module tmb_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sample_taken_flag_event_in,
    input  wire        count_event_in,
    output reg         sample_taken_flag_event_out,
    output reg         ovf_event_out,
    output reg         wave_out,
    output reg         wave_oe
);
    reg [7:0]  ctrla_q;
    reg [7:0]  ctrlb_q;
    reg [7:0]  evctrl_q;
    reg [15:0] cmp_q;
    reg [15:0] cnt_q;
    reg        sample_taken_flag_q;
    reg        ovf_q;
    reg        run_q;
    reg        hold_q;
    reg        phase_q;
    reg        wav_q;
    reg        immediate_trigger_q;
    reg [1:0]  arm_q;
    reg        lvl_d1_q;
    reg        div_q;
    reg        en_d1_q;
    reg        edge_d1_q;
    wire       c_rise;
    wire       c_fall;
    wire       c_lvl;
    wire       k_rise;

    // Capture and clock event lines each get their own synchroniser.
    tmb_edge u_sample_taken_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sample_taken_flag_event_in),
        .rise_q  (c_rise),
        .fall_q  (c_fall),
        .level   (c_lvl)
    );
    tmb_edge u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (count_event_in),
        .rise_q  (k_rise),
        .fall_q  (),
        .level   ()
    );

    wire       en      = ctrla_q[`TMB_CA_EN];
    wire [2:0] mode    = ctrlb_q[`TMB_CB_MODEHI:`TMB_CB_MODELO];
    wire [2:0] clock_source_select  = ctrla_q[`TMB_CA_CLKHI:`TMB_CA_CLKLO];
    wire       ei      = evctrl_q[`TMB_EV_EI];
    wire       anyedge = evctrl_q[`TMB_EV_EDGE];
    wire       ss      = (mode == `TMB_MODE_SS);

    // The counter tick: full rate, halved, or one per count event.
    // A cascaded high half must select events so overflows clock it.
    wire tick = en & ((clock_source_select == `TMB_CLK_DIV1) |
                ((clock_source_select == `TMB_CLK_DIV2) & div_q) |
                ((clock_source_select == `TMB_CLK_EVENT) & k_rise)); // RULE_19

    // APB decode helpers; every access completes without wait states.
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;

    function is_mapped;
        input [11:0] a;
        begin
            if (a == `TMB_OFF_CTRLA)       is_mapped = 1'b1;
            else if (a == `TMB_OFF_CTRLB)  is_mapped = 1'b1;
            else if (a == `TMB_OFF_EVCTRL) is_mapped = 1'b1;
            else if (a == `TMB_OFF_FLAGS)  is_mapped = 1'b1;
            else if (a == `TMB_OFF_STATUS) is_mapped = 1'b1;
            else if (a == `TMB_OFF_COUNT)  is_mapped = 1'b1;
            else if (a == `TMB_OFF_PERIOD_COMPARE_LOW_BYTE)  is_mapped = 1'b1;
            else if (a == `TMB_OFF_DUTY_COMPARE_HIGH_BYTE)  is_mapped = 1'b1;
            else                           is_mapped = 1'b0;
        end
    endfunction

    // Strobes for the registers that the counter logic also touches.
    wire cnt_wr   = wr & (paddr == `TMB_OFF_COUNT);
    wire period_compare_low_byte_rd = rd & (paddr == `TMB_OFF_PERIOD_COMPARE_LOW_BYTE);
    wire flag_wr  = wr & (paddr == `TMB_OFF_FLAGS);

    // Trigger qualification for single-shot mode.
    wire trig = ei & (c_rise | (anyedge & c_fall)); // RULE_10
    // An asynchronous edge cannot be used without a second clock, so
    // the immediate path sets the output from the raw synchronised
    // level change, one cycle ahead of the qualified trigger. The
    // previous level is kept here, since the edge cell keeps its own.
    wire trig_fast = ei & ctrlb_q[`TMB_CB_IMM] &
                     (c_lvl ^ lvl_d1_q) & (c_lvl | anyedge);
    // Wraparound and the capture-mode group are used in several places.
    wire at_max   = (cnt_q == `TMB_MAX);
    wire cap_mode = (mode == `TMB_MODE_PW) | (mode == `TMB_MODE_FPW);

    // Untriggered start on enable or a polarity change while enabled.
    wire auto_go = ss & en & ((~en_d1_q) |
                   (evctrl_q[`TMB_EV_EDGE] ^ edge_d1_q)); // RULE_11

    // Main counter, capture and flag logic.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= `TMB_BOTTOM;
            cmp_q    <= 16'h0000;
            sample_taken_flag_q   <= 1'b0;
            ovf_q    <= 1'b0;
            run_q    <= 1'b0;
            hold_q   <= 1'b0;
            phase_q  <= 1'b0;
            arm_q    <= 2'h0;
            lvl_d1_q <= 1'b0;
            div_q    <= 1'b0;
            en_d1_q  <= 1'b0;
            edge_d1_q <= 1'b0;
            sample_taken_flag_event_out <= 1'b0;
            ovf_event_out  <= 1'b0;
        end else begin
            div_q          <= ~div_q;
            en_d1_q        <= en;
            edge_d1_q      <= evctrl_q[`TMB_EV_EDGE];
            lvl_d1_q       <= c_lvl;
            sample_taken_flag_event_out <= 1'b0;
            ovf_event_out  <= 1'b0;
            // Flag clears first; a same-cycle set below wins.
            if (flag_wr & pwdata[`TMB_FL_SAMPLE_TAKEN_FLAG])
                sample_taken_flag_q <= 1'b0;
            if (flag_wr & pwdata[`TMB_FL_OVF])
                ovf_q <= 1'b0;
            if (period_compare_low_byte_rd & cap_mode)
                sample_taken_flag_q <= 1'b0; // RULE_02
            if (wr & (paddr == `TMB_OFF_PERIOD_COMPARE_LOW_BYTE))
                cmp_q[7:0] <= pwdata[7:0];
            if (wr & (paddr == `TMB_OFF_DUTY_COMPARE_HIGH_BYTE))
                cmp_q[15:8] <= pwdata[7:0];
            case (mode)
            `TMB_MODE_PW: begin
                if (tick)
                    cnt_q <= cnt_q + 16'h0001; // RULE_22
                if (ei & c_rise) begin
                    cnt_q   <= `TMB_BOTTOM; // RULE_01
                    phase_q <= 1'b1;
                end else if (ei & c_fall & phase_q) begin
                    cmp_q   <= cnt_q; // RULE_21
                    phase_q <= 1'b0;
                    sample_taken_flag_q  <= 1'b1; // RULE_01
                    sample_taken_flag_event_out <= 1'b1; // RULE_24
                end
            end
            `TMB_MODE_FPW: begin
                // phase 0 idle/armed, 1 counting high, hold = low half.
                if (tick & (phase_q | hold_q))
                    cnt_q <= cnt_q + 16'h0001;
                if (ei & c_rise & ~phase_q & ~hold_q & ~sample_taken_flag_q) begin
                    cnt_q   <= `TMB_BOTTOM; // RULE_05
                    phase_q <= 1'b1;
                end else if (ei & c_fall & phase_q) begin
                    cmp_q   <= cnt_q; // RULE_05
                    phase_q <= 1'b0;
                    hold_q  <= 1'b1;
                end else if (ei & c_rise & hold_q) begin
                    hold_q  <= 1'b0; // RULE_05
                    sample_taken_flag_q  <= 1'b1;
                    sample_taken_flag_event_out <= 1'b1; // RULE_24
                end
            end
            `TMB_MODE_SS: begin
                // Stopped, armed, running, then held low for one tick.
                if (arm_q != 2'h0) begin
                    arm_q <= arm_q - 2'h1;
                    if (arm_q == 2'h1) begin
                        cnt_q <= `TMB_BOTTOM; // RULE_09
                        run_q <= 1'b1;
                    end
                end else if (run_q) begin
                    if (cnt_q == cmp_q) begin
                        run_q  <= 1'b0; // RULE_08
                        hold_q <= 1'b1;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 16'h0001; // RULE_07
                    end
                end else if (hold_q) begin
                    if (tick)
                        hold_q <= 1'b0; // RULE_08
                end else if (trig | trig_fast) begin
                    arm_q <= `TMB_SS_DELAY; // RULE_12
                end else if (auto_go & (cnt_q != `TMB_MAX) & ~cnt_wr) begin
                    cnt_q <= `TMB_BOTTOM; // RULE_11
                    run_q <= 1'b1;
                end
            end
            `TMB_MODE_PWM: begin
                // The low compare byte is the last count of the period.
                if (tick) begin
                    if (cnt_q[7:0] >= cmp_q[7:0])
                        cnt_q <= `TMB_BOTTOM; // RULE_14
                    else
                        cnt_q <= cnt_q + 16'h0001;
                end
            end
            default: begin
                // Modes outside this block just count freely.
                if (tick)
                    cnt_q <= cnt_q + 16'h0001;
            end
            endcase
            // A software write to the count lands last, so it wins over a
            // tick or restart in the same cycle; writing the top value is
            // also how software holds off the untriggered single-shot start.
            if (cnt_wr)
                cnt_q <= pwdata[15:0]; // RULE_11
            // Wraparound in the capture modes drives the chain.
            if (cap_mode & tick & at_max) begin
                ovf_q         <= 1'b1; // RULE_03
                ovf_event_out <= 1'b1; // RULE_19
            end
        end
    end

    // Waveform generation; output enable gates the pin.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wav_q    <= 1'b0;
            immediate_trigger_q  <= 1'b0;
            wave_out <= 1'b0;
            wave_oe  <= 1'b0;
        end else begin
            immediate_trigger_q <= ss & ~run_q & ~hold_q & (arm_q == 2'h0) & trig_fast;
            if (ss)
                wav_q <= run_q & (cnt_q != cmp_q); // RULE_07
            else if (mode == `TMB_MODE_PWM)
                wav_q <= (cnt_q[7:0] < cmp_q[15:8]); // RULE_15
            else
                wav_q <= ctrlb_q[`TMB_CB_INIT]; // RULE_17
            wave_oe  <= ctrlb_q[`TMB_CB_OE]; // RULE_16
            // With the immediate trigger the output bridges the arming
            // cycles and the first running cycle, before wav_q catches up;
            // without run_q here the pulse would drop for one cycle.
            wave_out <= ctrlb_q[`TMB_CB_OE] &
                        (wav_q | immediate_trigger_q | (ss & ctrlb_q[`TMB_CB_IMM] &
                         ((arm_q != 2'h0) | run_q))); // RULE_12
        end
    end

    // APB register writes and read data.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrla_q  <= 8'h00;
            ctrlb_q  <= 8'h00;
            evctrl_q <= 8'h00;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            // Zero wait states: pready rises in the access cycle.
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~is_mapped(paddr);
            if (wr & (paddr == `TMB_OFF_CTRLA))
                ctrla_q <= pwdata[7:0];
            else if (wr & (paddr == `TMB_OFF_CTRLB))
                ctrlb_q <= pwdata[7:0];
            else if (wr & (paddr == `TMB_OFF_EVCTRL))
                evctrl_q <= pwdata[7:0];
            // Read data is loaded in the setup cycle so it stands while
            // pready is high.
            prdata <= 32'h00000000;
            if (psel & ~penable & ~pwrite) begin
                if (paddr == `TMB_OFF_CTRLA)
                    prdata <= {24'h000000, ctrla_q};
                else if (paddr == `TMB_OFF_CTRLB)
                    prdata <= {24'h000000, ctrlb_q};
                else if (paddr == `TMB_OFF_EVCTRL)
                    prdata <= {24'h000000, evctrl_q};
                else if (paddr == `TMB_OFF_FLAGS)
                    prdata <= {30'h0, ovf_q, sample_taken_flag_q};
                else if (paddr == `TMB_OFF_STATUS)
                    prdata <= {31'h0, run_q}; // RULE_13
                else if (paddr == `TMB_OFF_COUNT)
                    prdata <= {16'h0000, cnt_q};
                else if (paddr == `TMB_OFF_PERIOD_COMPARE_LOW_BYTE)
                    prdata <= {24'h000000, cmp_q[7:0]};
                else if (paddr == `TMB_OFF_DUTY_COMPARE_HIGH_BYTE)
                    prdata <= {24'h000000, cmp_q[15:8]};
            end
        end
    end
endmodule

// ### dv/tmb_chk_assertions.sv
// Port checker for tmb_timer, bound into every instance.
// Assumes APB writes land at the edge that samples pready high.
`timescale 1ns/1ps
`include "tmb_defs.vh"
module tmb_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        sample_taken_flag_event_in,
    input wire        sample_taken_flag_event_out,
    input wire        ovf_event_out,
    input wire        wave_out,
    input wire        wave_oe
);
    reg  [6:0] ctrlb_q;
    wire [6:0] ctrlb_d;
    wire       wr_b;
    // Shadow of the mode word, since the design's copy is not a port.
    assign wr_b = psel && penable && pwrite && pready
                  && paddr == `TMB_OFF_CTRLB;
    assign ctrlb_d = wr_b ? pwdata[6:0] : ctrlb_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrlb_q <= 7'h00;
        else
            ctrlb_q <= ctrlb_d;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_sample_taken_flag_pulse;
        sample_taken_flag_event_out |=> !sample_taken_flag_event_out;
    endproperty
    a_sample_taken_flag_pulse: assert property (p_sample_taken_flag_pulse)
        else $error("capture event longer than one cycle");
    property p_ovf_pulse;
        ovf_event_out |=> !ovf_event_out;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse)
        else $error("overflow event longer than one cycle");
    property p_no_drive;
        !wave_oe |-> !wave_out;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("waveform driven with output disabled");
    property p_oe_follow;
        wr_b |-> ##[1:3] (wave_oe == ctrlb_q[`TMB_CB_OE]);
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("output enable does not follow its bit");
    // Three stable cycles cover the registered output path.
    property p_init_level;
        wave_oe && ctrlb_q[2:1] != 2'b11 && ctrlb_q == $past(ctrlb_q, 3)
            |-> wave_out == ctrlb_q[`TMB_CB_INIT];
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("waveform differs from initial level bit");
    property p_pw_sample_taken_flag;
        sample_taken_flag_event_out && ctrlb_q[2:0] == `TMB_MODE_PW
            |-> !$past(sample_taken_flag_event_in, 4) && $past(sample_taken_flag_event_in, 5);
    endproperty
    a_pw_sample_taken_flag: assert property (p_pw_sample_taken_flag)
        else $error("pulse-width capture not on a falling edge");
    property p_fpw_sample_taken_flag;
        sample_taken_flag_event_out && ctrlb_q[2:0] == `TMB_MODE_FPW
            |-> $past(sample_taken_flag_event_in, 4) && !$past(sample_taken_flag_event_in, 5);
    endproperty
    a_fpw_sample_taken_flag: assert property (p_fpw_sample_taken_flag)
        else $error("frequency capture not on a rising edge");
    property p_ss_low;
        $fell(wave_out) && ctrlb_q[2:0] == `TMB_MODE_SS |=> !wave_out;
    endproperty
    a_ss_low: assert property (p_ss_low)
        else $error("single-shot output not held low after stop");
endmodule
bind tmb_timer tmb_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .sample_taken_flag_event_in(sample_taken_flag_event_in), .sample_taken_flag_event_out(sample_taken_flag_event_out),
    .ovf_event_out(ovf_event_out), .wave_out(wave_out), .wave_oe(wave_oe)
);

// ### dv/tmb_ev_src.sv
// Event source model standing in for the routing fabric.
// Assumes its tasks are called just after a rising edge of pclk.
`timescale 1ns/1ps
module tmb_ev_src (
    input  wire pclk,
    output reg  sample_taken_flag_ev,
    output reg  count_ev
);
    initial begin
        sample_taken_flag_ev = 1'b0;
        count_ev = 1'b0;
    end
    // Each level is held for hold cycles; callers never pass less than
    // two, so the synchroniser cannot miss an edge.
    task drive(input reg lvl, input integer hold);
        begin
            sample_taken_flag_ev <= lvl;
            repeat (hold < 2 ? 2 : hold) @(posedge pclk);
        end
    endtask
    // Pulses the count line k times, three cycles high and three low,
    // so every rising edge gets through the synchroniser on its own.
    task pulse(input integer k);
        begin
            repeat (k) begin
                count_ev <= 1'b1;
                repeat (3) @(posedge pclk);
                count_ev <= 1'b0;
                repeat (3) @(posedge pclk);
            end
        end
    endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for tmb_timer: APB tasks and mode scenarios.
// Assumes the checker bind and the event source model are compiled.
`timescale 1ns/1ps
`include "tmb_defs.vh"
module tb;
    reg         pclk, presetn, psel, penable, pwrite, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, sample_taken_flag_in, cnt_in, sample_taken_flag_out, ovf_out;
    wire        wave_out, wave_oe;
    integer     bad_count, compares, cyc, n, m, d_sync;
    tmb_timer dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_taken_flag_event_in(sample_taken_flag_in),
        .count_event_in(cnt_in), .sample_taken_flag_event_out(sample_taken_flag_out),
        .ovf_event_out(ovf_out), .wave_out(wave_out), .wave_oe(wave_oe)
    );
    tmb_ev_src ev_u (.pclk(pclk), .sample_taken_flag_ev(sample_taken_flag_in), .count_ev(cnt_in));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // A hang is cut short well past the several hundred cycles needed.
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            complete_run;
        end
    end
    task complete_run;
        begin
            $display("compares %0d mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // One APB transfer; read data is taken at the edge pready is seen.
    task apb(input reg w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("unexpected %s: expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task bchk(input string nm, input reg e, input reg g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task rck(input string nm, input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(nm, e, rd);
        end
    endtask
    task rrng(input string nm, input [11:0] a, input [31:0] lo, hi);
        begin
            apb(1'b0, a, 32'h0);
            compares = compares + 1;
            if ((rd >= lo && rd <= hi) !== 1'b1) begin
                bad_count = bad_count + 1;
                $display("unexpected %s: expected %0d..%0d seen %h",
                         nm, lo, hi, rd);
            end
        end
    endtask
    // Counts edges until the waveform is sampled at level v.
    task waitw(input reg v, output integer c);
        begin
            c = 0;
            while (wave_out !== v && c < 300) begin
                @(posedge pclk);
                c = c + 1;
            end
        end
    endtask
    task setup(input [31:0] b, input [31:0] e, input [31:0] cnt);
        begin
            wr(`TMB_OFF_CTRLA, 32'h0);
            wr(`TMB_OFF_EVCTRL, e);
            wr(`TMB_OFF_CTRLB, b);
            wr(`TMB_OFF_COUNT, cnt);
            wr(`TMB_OFF_CTRLA, 32'h1);
            wr(`TMB_OFF_FLAGS, 32'h3);
        end
    endtask
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        bad_count = 0;
        compares = 0;
        cyc = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rck("ctrla", `TMB_OFF_CTRLA, 32'h0);
        apb(1'b0, 12'hffc, 32'h0);
        bchk("slverr", 1'b1, err);
        $display("reset test done");
        setup(32'h4, 32'h1, 32'h0);
        ev_u.drive(1'b1, 20);
        ev_u.drive(1'b0, 8);
        rck("sample_taken_flag flag", `TMB_OFF_FLAGS, 32'h1);
        rrng("width", `TMB_OFF_PERIOD_COMPARE_LOW_BYTE, 19, 21);
        rck("flag cleared", `TMB_OFF_FLAGS, 32'h0);
        wr(`TMB_OFF_COUNT, 32'hfffd);
        n = 0;
        while (ovf_out !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n = n + 1;
        end
        bchk("ovf event", 1'b1, ovf_out);
        rck("ovf flag", `TMB_OFF_FLAGS, 32'h2);
        rrng("wrapped", `TMB_OFF_COUNT, 0, 40);
        $display("pulse width test done");
        setup(32'h5, 32'h1, 32'h0);
        ev_u.drive(1'b1, 10);
        ev_u.drive(1'b0, 15);
        ev_u.drive(1'b1, 8);
        rrng("period", `TMB_OFF_COUNT, 24, 26);
        rrng("high time", `TMB_OFF_PERIOD_COMPARE_LOW_BYTE, 9, 11);
        ev_u.drive(1'b0, 4);
        ev_u.drive(1'b1, 6);
        rrng("restart", `TMB_OFF_COUNT, 1, 20);
        $display("frequency test done");
        wr(`TMB_OFF_PERIOD_COMPARE_LOW_BYTE, 32'd10);
        wr(`TMB_OFF_DUTY_COMPARE_HIGH_BYTE, 32'h0);
        setup(32'h16, 32'h1, 32'hffff);
        repeat (10) @(posedge pclk);
        bchk("idle out", 1'b0, wave_out);
        rck("idle status", `TMB_OFF_STATUS, 32'h0);
        ev_u.drive(1'b0, 4);
        ev_u.drive(1'b1, 2);
        waitw(1'b1, n);
        rck("run status", `TMB_OFF_STATUS, 32'h1);
        waitw(1'b0, m);
        chk("shot long", 1, (m + 3 >= 10 && m + 3 <= 12));
        rck("stop status", `TMB_OFF_STATUS, 32'h0);
        ev_u.drive(1'b0, 12);
        bchk("fall ignored", 1'b0, wave_out);
        setup(32'h16, 32'h11, 32'd10);
        ev_u.drive(1'b1, 30);
        ev_u.drive(1'b0, 2);
        waitw(1'b1, n);
        bchk("any edge", 1'b1, wave_out);
        d_sync = n + 2;
        waitw(1'b0, n);
        setup(32'h56, 32'h11, 32'hffff);
        ev_u.drive(1'b1, 2);
        waitw(1'b1, n);
        // The sync path adds the edge flop, two arming cycles and a stage.
        chk("immediate_trigger lead", d_sync - 4, n + 2);
        waitw(1'b0, n);
        $display("single-shot test done");
        wr(`TMB_OFF_PERIOD_COMPARE_LOW_BYTE, 32'd9);
        wr(`TMB_OFF_DUTY_COMPARE_HIGH_BYTE, 32'd3);
        setup(32'h17, 32'h0, 32'h0);
        waitw(1'b0, n);
        waitw(1'b1, n);
        waitw(1'b0, n);
        chk("pwm high", 3, n);
        waitw(1'b1, m);
        chk("pwm period", 10, n + m);
        $display("pwm test done");
        setup(32'h4, 32'h0, 32'h0);
        wr(`TMB_OFF_CTRLA, 32'h2f);
        wr(`TMB_OFF_COUNT, 32'h0);
        ev_u.pulse(5);
        rck("chain count", `TMB_OFF_COUNT, 32'h5);
        $display("chain test done");
        setup(32'h34, 32'h0, 32'h0);
        repeat (4) @(posedge pclk);
        bchk("init level", 1'b1, wave_out);
        wr(`TMB_OFF_CTRLB, 32'h24);
        repeat (4) @(posedge pclk);
        bchk("oe off", 1'b0, wave_oe);
        bchk("no drive", 1'b0, wave_out);
        $display("output test done");
        complete_run;
    end
endmodule
